// ==== verilog/async_serial_port_regs.vh ====
`ifndef ASYNC_SERIAL_PORT_REGS_VH
`define ASYNC_SERIAL_PORT_REGS_VH

// Register addresses
`define ADDR_MODE 16'hFF70
`define ADDR_BAUD 16'hFF71
`define ADDR_DATA 16'hFF72
`define ADDR_STAT 16'hFF73

// Reset values
`define MODE_RESET 8'h01
`define BAUD_RESET 8'h1F
`define BUF_RESET 8'hFF
`define STAT_RESET 8'h00
`define RD_IDLE 8'h00

// Mode register fields
`define POWER_BIT 7
`define TXE_BIT 6
`define RXE_BIT 5
`define PAR_HI 4
`define PAR_LO 3
`define CL_BIT 2
`define SL_BIT 1
`define MODE_FIXED 8'h01

// Parity modes
`define PAR_NONE 2'h0
`define PAR_ZERO 2'h1
`define PAR_ODD 2'h2
`define PAR_EVEN 2'h3

// Baud generator fields
`define TPS_HI 7
`define TPS_LO 6
`define MDL_HI 4
`define MDL_LO 0
`define BAUD_MASK 8'hDF
`define TPS_TIMER 2'h0
`define TPS_DIV2 2'h1
`define TPS_DIV8 2'h2
`define TPS_DIV32 2'h3

// Error status fields
`define PE_BIT 2
`define FE_BIT 1
`define OVE_BIT 0

// Frame lengths in bits
`define LEN7 4'h7
`define LEN8 4'h8
`define SHIFT_W 4'h9

`endif

// ==== verilog/async_serial_port_core.v ====
// Operation
// (RL1) Completed character moves shifter into buffer
// (RL2) 7-bit characters leave buffer MSB zero
// (RL3) Overrun discards new character, buffer kept
// (RL4) Buffer read-only, all ones on reset/power-off
// (RL5) Writing transmit data starts transmission; unreadable
// (RL6) Transmit register ones on reset/power/enable off
// (RL7) Software waits base clock, then for completion
// (RL8) Power off stops clock, resets whole circuit
// (RL9) Power off forces receive input high
// (RL10) Enable clear resets its direction circuit
// (RL11) Two-bit field selects none/zero/odd/even parity
// (RL12) Zero parity mode never flags parity error
// (RL13) Length bit selects seven or eight bits
// (RL14) Stop select sets transmit stops; receive one
// (RL15) Receiver checks only first stop bit
// (RL16) Software enables receiver only while line high
// (RL17) Enables synchronised to base clock; two-clock gap
// (RL18) Power on before enables, off after
// (RL19) Software changes format only while disabled
// (RL20) Status read-only, cleared by reset/off/read
// (RL21) Status bits: parity, framing, overrun
// (RL22) Characters always least significant bit first
// (RL23) Bit rate is counter output halved
// (RL24) Start bit low, line idles high
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "async_serial_port_regs.vh"

module async_serial_port_core (
  input wire clk_sys,
  input wire rst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire timer_tick,
  input wire serial_in_line,
  output reg serial_out_line,
  output reg tx_done_interrupt,
  output reg rx_done_pulse,
  output reg rx_error_pulse
);

  localparam [2:0] RX_IDLE = 3'b001;
  localparam [2:0] RX_START = 3'b010;
  localparam [2:0] RX_BITS = 3'b100;

  // Divider count that wraps after k steps
  function [4:0] cnt_next;
    input [4:0] c;
    input [4:0] k;
    begin
      if (c >= k - 5'h01) begin
        cnt_next = 5'h00;
      end else begin
        cnt_next = c + 5'h01;
      end
    end
  endfunction

  // Parity bit for a data byte in the given mode
  function par_bit;
    input [7:0] d;
    input [1:0] ps;
    begin
      case (ps)
        `PAR_ODD: par_bit = ~^d;
        `PAR_EVEN: par_bit = ^d;
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  // Character length in bits
  function [3:0] char_len;
    input cl;
    begin
      char_len = cl ? `LEN8 : `LEN7;
    end
  endfunction

  reg [7:0] mode_q;
  reg [7:0] baud_q;
  reg [4:0] pre_q;
  reg [4:0] bcnt_q;
  reg txe_q;
  reg rxe_q;
  reg in_meta_q;
  reg in_sync_q;
  reg [7:0] txs_q;
  reg [11:0] tx_frame_q;
  reg [3:0] tx_left_q;
  reg tx_busy_q;
  reg tx_ph_q;
  reg [2:0] rx_state_q;
  reg [4:0] rcnt_q;
  reg rph_q;
  reg [3:0] rx_left_q;
  reg [8:0] rx_sh_q;
  reg [7:0] rxb_q;
  reg rxb_full_q;
  reg [2:0] stat_q;

  wire power = mode_q[`POWER_BIT];
  wire [1:0] ps = {mode_q[`PAR_HI], mode_q[`PAR_LO]};
  wire cl = mode_q[`CL_BIT];
  wire sl = mode_q[`SL_BIT];
  wire [4:0] k = baud_q[`MDL_HI:`MDL_LO];
  wire [1:0] tps = baud_q[`TPS_HI:`TPS_LO];
  wire wr_mode = reg_wr && (reg_addr == `ADDR_MODE);
  wire wr_baud = reg_wr && (reg_addr == `ADDR_BAUD);
  wire wr_data = reg_wr && (reg_addr == `ADDR_DATA);
  wire rd_data = reg_rd && (reg_addr == `ADDR_DATA);
  wire rd_stat = reg_rd && (reg_addr == `ADDR_STAT);
  wire rx_line = power ? in_sync_q : 1'b1; // RL9
  wire [3:0] par_len = (ps == `PAR_NONE) ? 4'h0 : 4'h1;

  reg base_tick;
  wire tx_half = base_tick && (cnt_next(bcnt_q, k) == 5'h00);
  wire rx_half = base_tick && (cnt_next(rcnt_q, k) == 5'h00);
  wire tx_bit_tick = tx_half && tx_ph_q; // RL23

  // Base clock select; held still while powered down
  always @* begin
    base_tick = 1'b0;
    if (power) begin // RL8
      case (tps)
        `TPS_TIMER: base_tick = timer_tick;
        `TPS_DIV2: base_tick = pre_q[0];
        `TPS_DIV8: base_tick = &pre_q[2:0];
        default: base_tick = &pre_q[4:0];
      endcase
    end
  end

  // Mode and baud generator registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= `MODE_RESET;
      baud_q <= `BAUD_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata | `MODE_FIXED;
      end
      if (wr_baud) begin
        baud_q <= reg_wdata & `BAUD_MASK;
      end
    end
  end

  // Prescaler and transmit-only baud counter; receiver counts with rcnt_q
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= 5'h00;
      bcnt_q <= 5'h00;
    end else if (!power) begin
      pre_q <= 5'h00; // RL8
      bcnt_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
      if (base_tick) begin
        bcnt_q <= cnt_next(bcnt_q, k); // RL23
      end
    end
  end

  // Enables take effect on base clock ticks; power off clears them at once
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txe_q <= 1'b0;
      rxe_q <= 1'b0;
    end else if (!power) begin
      txe_q <= 1'b0;
      rxe_q <= 1'b0;
    end else if (base_tick) begin
      txe_q <= mode_q[`TXE_BIT]; // RL17
      rxe_q <= mode_q[`RXE_BIT]; // RL17
    end
  end

  // Two-stage synchroniser on the receive pin
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_meta_q <= 1'b1;
      in_sync_q <= 1'b1;
    end else begin
      in_meta_q <= serial_in_line;
      in_sync_q <= in_meta_q;
    end
  end

  // Transmit frame: data LSB first, parity, stop bits
  reg [11:0] frame_d;
  reg [7:0] tdat;
  always @* begin
    frame_d = 12'hFFF;
    tdat = cl ? reg_wdata : {1'b0, reg_wdata[6:0]}; // RL13
    if (cl) begin
      frame_d[7:0] = tdat; // RL22
    end else begin
      frame_d[6:0] = tdat[6:0];
    end
    if (ps != `PAR_NONE) begin
      frame_d[char_len(cl)] = par_bit(tdat, ps); // RL11
    end
  end

  // Transmitter
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txs_q <= `BUF_RESET;
      tx_frame_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'b0;
      tx_ph_q <= 1'b0;
      serial_out_line <= 1'b1;
      tx_done_interrupt <= 1'b0;
    end else begin
      tx_done_interrupt <= 1'b0;
      if (!power || !txe_q) begin
        txs_q <= `BUF_RESET; // RL6
        tx_busy_q <= 1'b0; // RL10
        tx_left_q <= 4'h0;
        tx_ph_q <= 1'b0;
        serial_out_line <= 1'b1; // RL24
      end else if (wr_data) begin
        txs_q <= reg_wdata; // RL5
        tx_frame_q <= frame_d;
        tx_left_q <= char_len(cl) + par_len + (sl ? 4'h2 : 4'h1); // RL14
        tx_busy_q <= 1'b1;
        tx_ph_q <= 1'b0;
        serial_out_line <= 1'b0; // RL24
      end else if (tx_busy_q) begin
        if (tx_half) begin
          tx_ph_q <= ~tx_ph_q;
        end
        if (tx_bit_tick) begin
          if (tx_left_q == 4'h0) begin
            tx_busy_q <= 1'b0;
            tx_done_interrupt <= 1'b1;
          end else begin
            serial_out_line <= tx_frame_q[0]; // RL22
            tx_frame_q <= {1'b1, tx_frame_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
          end
        end
      end
    end
  end

  // Received character unpacked from the shifter
  wire [3:0] got = char_len(cl) + par_len;
  wire [8:0] aligned = rx_sh_q >> (`SHIFT_W - got);
  wire [7:0] rdat = cl ? aligned[7:0] : {1'b0, aligned[6:0]}; // RL2
  wire rpar = cl ? aligned[8] : aligned[7];
  wire chk = (ps == `PAR_ODD) || (ps == `PAR_EVEN); // RL12
  wire pe_now = chk && (par_bit(rdat, ps) != rpar); // RL11
  wire fe_now = !rx_line; // RL15
  wire rx_end = (rx_state_q == RX_BITS) && rx_half && rph_q &&
    (rx_left_q == 4'h1);

  // Receive sequencer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_state_q <= RX_IDLE;
      rcnt_q <= 5'h00;
      rph_q <= 1'b0;
      rx_left_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else if (!power || !rxe_q) begin
      rx_state_q <= RX_IDLE; // RL10
      rcnt_q <= 5'h00;
      rph_q <= 1'b0;
      rx_left_q <= 4'h0;
    end else begin
      if (base_tick) begin
        rcnt_q <= cnt_next(rcnt_q, k);
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (!rx_line) begin
            rcnt_q <= 5'h00; // RL24
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_half) begin
            if (!rx_line) begin
              rx_state_q <= RX_BITS;
              rph_q <= 1'b0;
              rx_left_q <= got + 4'h1;
            end else begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        RX_BITS: begin
          if (rx_half) begin
            rph_q <= ~rph_q;
            if (rph_q) begin
              if (rx_left_q == 4'h1) begin
                rx_state_q <= RX_IDLE; // RL14
              end else begin
                rx_sh_q <= {rx_line, rx_sh_q[8:1]}; // RL22
              end
              rx_left_q <= rx_left_q - 4'h1;
            end
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer, unread marker and error status
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxb_q <= `BUF_RESET;
      rxb_full_q <= 1'b0;
      stat_q <= 3'h0;
      rx_done_pulse <= 1'b0;
      rx_error_pulse <= 1'b0;
    end else if (!power) begin
      rxb_q <= `BUF_RESET; // RL4
      rxb_full_q <= 1'b0;
      stat_q <= 3'h0; // RL20
      rx_done_pulse <= 1'b0;
      rx_error_pulse <= 1'b0;
    end else if (!rxe_q) begin
      stat_q <= 3'h0; // RL20
      rxb_full_q <= 1'b0;
      rx_done_pulse <= 1'b0;
      rx_error_pulse <= 1'b0;
    end else begin
      rx_done_pulse <= rx_end;
      rx_error_pulse <= rx_end &&
        (pe_now || fe_now || (rxb_full_q && !rd_data)); // RL21
      if (rd_stat) begin
        stat_q <= 3'h0; // RL20
      end
      if (rd_data) begin
        rxb_full_q <= 1'b0;
      end
      if (rx_end) begin
        if (rxb_full_q && !rd_data) begin
          stat_q[`OVE_BIT] <= 1'b1; // RL21
        end else begin
          rxb_q <= rdat; // RL1
          rxb_full_q <= 1'b1; // RL3
        end
        if (pe_now) begin
          stat_q[`PE_BIT] <= 1'b1; // RL21
        end
        if (fe_now) begin
          stat_q[`FE_BIT] <= 1'b1; // RL21
        end
      end
    end
  end

  // Read data, valid in the cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= `RD_IDLE;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_MODE) begin
        reg_rdata <= mode_q;
      end else if (reg_addr == `ADDR_BAUD) begin
        reg_rdata <= baud_q;
      end else if (reg_addr == `ADDR_DATA) begin
        reg_rdata <= rxb_q; // RL4
      end else if (reg_addr == `ADDR_STAT) begin
        reg_rdata <= {5'h00, stat_q};
      end else begin
        reg_rdata <= `RD_IDLE;
      end
    end else begin
      reg_rdata <= `RD_IDLE;
    end
  end

endmodule // async_serial_port_core

// ==== tb/async_serial_port_core_asserts.sv ====
`timescale 1ns/10ps
`include "async_serial_port_regs.vh"
module async_serial_port_core_asserts (
  input wire clk_sys,
  input wire rst,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire serial_out_line,
  input wire tx_done_interrupt,
  input wire rx_done_pulse,
  input wire rx_error_pulse
);
  reg pwr_q;
  wire rd_stat = reg_rd && reg_addr == `ADDR_STAT;
  wire rd_data = reg_rd && reg_addr == `ADDR_DATA;
  wire rd_mode = reg_rd && reg_addr == `ADDR_MODE;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow of the power bit as last written
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_q <= 1'b0;
    end else if (reg_wr && reg_addr == `ADDR_MODE) begin
      pwr_q <= reg_wdata[`POWER_BIT];
    end
  end
  // Two status reads with no reception finishing around them
  sequence stat_read_twice;
    (rd_stat && !rx_done_pulse) ##1 !rx_done_pulse
      ##1 (rd_stat && !rx_done_pulse) ##1 !rx_done_pulse;
  endsequence
  a_done_after_stop: assert property (
    tx_done_interrupt |-> serial_out_line && $past(serial_out_line))
    else $error("done without stop level");
  a_rx_pulse_single: assert property (
    rx_done_pulse |=> !rx_done_pulse)
    else $error("receive pulse too long");
  a_err_with_done: assert property (
    rx_error_pulse |-> rx_done_pulse)
    else $error("error pulse alone");
  a_stat_upper_zero: assert property (
    $past(rd_stat) |-> reg_rdata[7:3] == 5'h00)
    else $error("status upper bits set");
  a_stat_read_clears: assert property (
    stat_read_twice |-> reg_rdata == 8'h00)
    else $error("status not cleared by read");
  a_mode_bit_one: assert property (
    $past(rd_mode) |-> reg_rdata[0])
    else $error("mode bit 0 low");
  a_off_buffer_ones: assert property (
    !$past(pwr_q, 2) && $past(rd_data) |-> reg_rdata == 8'hFF)
    else $error("buffer not ones when off");
  a_off_status_zero: assert property (
    !$past(pwr_q, 2) && $past(rd_stat) |-> reg_rdata == 8'h00)
    else $error("status set when off");
  a_off_line_idle: assert property (
    !pwr_q && !$past(pwr_q, 2) |-> serial_out_line && !tx_done_interrupt)
    else $error("line active when off");
endmodule // async_serial_port_core_asserts
bind async_serial_port_core async_serial_port_core_asserts
  async_serial_port_core_asserts_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .serial_out_line(serial_out_line),
  .tx_done_interrupt(tx_done_interrupt),
  .rx_done_pulse(rx_done_pulse),
  .rx_error_pulse(rx_error_pulse)
);

// ==== tb/remote_station.sv ====
`timescale 1ns/10ps
module remote_station #(parameter integer BIT_CLKS = 32) (
  input wire clk_sys,
  input wire line_from_dut,
  output reg line_to_dut,
  output reg [7:0] got_byte
);
  integer i;
  integer j;
  // Line idles high between characters
  initial begin
    line_to_dut = 1'b1;
    got_byte = 8'h00;
  end
  // Low start bit, then n bits least significant first
  task send(input [9:0] bits, input integer n);
    begin
      @(posedge clk_sys) line_to_dut <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_sys);
      for (i = 0; i < n; i = i + 1) begin
        line_to_dut <= bits[i];
        repeat (BIT_CLKS) @(posedge clk_sys);
      end
      line_to_dut <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
  // Start bit length follows the sender's counter phase, so timing is
  // taken from its rising end: characters sent here carry a one in bit 0
  always begin
    @(negedge line_from_dut);
    @(posedge line_from_dut);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (j = 0; j < 8; j = j + 1) begin
      got_byte[j] <= line_from_dut;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  end
endmodule // remote_station

// ==== tb/async_serial_port_core_test.sv ====
`timescale 1ns/10ps
`include "async_serial_port_regs.vh"
module async_serial_port_core_test;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [2:0] k;
  reg timer_tick = 1'b0;
  reg [7:0] done_seen = 8'h00;
  reg [7:0] err_seen = 8'h00;
  wire [7:0] reg_rdata;
  wire [7:0] got_byte;
  wire serial_out_line;
  wire serial_in_line;
  wire tx_done_interrupt;
  wire rx_done_pulse;
  wire rx_error_pulse;
  integer failures = 0;
  integer check_count = 0;
  integer i;
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  // Base clock strobe for the timer select, and receive pulse counters
  always @(posedge clk_sys) begin
    timer_tick <= ~timer_tick;
    if (rx_done_pulse === 1'b1) begin
      done_seen <= done_seen + 8'h01;
    end
    if (rx_error_pulse === 1'b1) begin
      err_seen <= err_seen + 8'h01;
    end
  end
  async_serial_port_core async_serial_port_core_i (.clk_sys(clk_sys),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_tick(timer_tick), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line),
    .tx_done_interrupt(tx_done_interrupt),
    .rx_done_pulse(rx_done_pulse), .rx_error_pulse(rx_error_pulse));
  remote_station remote_station_i (.clk_sys(clk_sys),
    .line_from_dut(serial_out_line), .line_to_dut(serial_in_line),
    .got_byte(got_byte));
  task check(input [7:0] seen, input [7:0] expected);
    begin
      check_count = check_count + 1;
      if (seen !== expected) begin
        failures = failures + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen,
          expected);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog against a hung handshake
  initial begin
    #1000000;
    failures = failures + 1;
    print_verdict;
  end
  // Test sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`ADDR_MODE, `MODE_RESET);
    rd(`ADDR_DATA, `BUF_RESET);
    wr(`ADDR_STAT, 8'h07);
    rd(`ADDR_STAT, `STAT_RESET);
    rd(16'hFF7F, `RD_IDLE);
    $display("reset test done");
    wr(`ADDR_BAUD, 8'h48);
    wr(`ADDR_MODE, 8'h81);
    wr(`ADDR_MODE, 8'hE5);
    repeat (8) @(posedge clk_sys);
    wr(`ADDR_DATA, 8'h55);
    rd(`ADDR_DATA, `BUF_RESET);
    i = 0;
    while (tx_done_interrupt !== 1'b1 && i < 600) begin
      @(posedge clk_sys);
      #1 i = i + 1;
    end
    check({7'h00, tx_done_interrupt}, 8'h01);
    check(got_byte, 8'h55);
    wr(`ADDR_DATA, 8'h0F);
    repeat (100) @(posedge clk_sys);
    wr(`ADDR_MODE, 8'hA5);
    repeat (8) @(posedge clk_sys);
    check({7'h00, serial_out_line}, 8'h01);
    $display("transmit test done");
    remote_station_i.send({1'b1, 8'hA3}, 9);
    rd(`ADDR_DATA, 8'hA3);
    remote_station_i.send({1'b1, 8'h11}, 9);
    remote_station_i.send({1'b1, 8'h22}, 9);
    rd(`ADDR_STAT, 8'h01);
    rd(`ADDR_STAT, 8'h00);
    rd(`ADDR_DATA, 8'h11);
    remote_station_i.send({1'b0, 8'h3C}, 9);
    rd(`ADDR_STAT, 8'h02);
    rd(`ADDR_DATA, 8'h3C);
    check(done_seen, 8'h04);
    check(err_seen, 8'h02);
    $display("receive test done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(`ADDR_MODE, 8'h81);
      repeat (4) @(posedge clk_sys);
      wr(`ADDR_MODE, 8'hA7 | {3'h0, k[1:0], 3'h0});
      repeat (4) @(posedge clk_sys);
      if (k == 0) remote_station_i.send({1'b1, 8'h5A}, 9);
      else remote_station_i.send({2'b11, 8'h5A}, 10);
      rd(`ADDR_STAT, (k == 3) ? 8'h04 : 8'h00);
      rd(`ADDR_DATA, 8'h5A);
    end
    $display("parity test done");
    wr(`ADDR_MODE, 8'h81);
    repeat (4) @(posedge clk_sys);
    wr(`ADDR_MODE, 8'hA1);
    remote_station_i.send({1'b1, 7'h7F}, 8);
    rd(`ADDR_DATA, 8'h7F);
    remote_station_i.send({1'b0, 7'h2B}, 8);
    wr(`ADDR_MODE, 8'h81);
    repeat (4) @(posedge clk_sys);
    rd(`ADDR_STAT, 8'h00);
    wr(`ADDR_MODE, 8'h01);
    repeat (4) @(posedge clk_sys);
    rd(`ADDR_DATA, `BUF_RESET);
    remote_station_i.send({1'b1, 8'h00}, 9);
    rd(`ADDR_DATA, `BUF_RESET);
    rd(`ADDR_STAT, 8'h00);
    $display("power test done");
    wr(`ADDR_BAUD, 8'h08);
    wr(`ADDR_MODE, 8'h81);
    repeat (4) @(posedge clk_sys);
    wr(`ADDR_MODE, 8'hA5);
    repeat (4) @(posedge clk_sys);
    remote_station_i.send({1'b1, 8'hC3}, 9);
    rd(`ADDR_DATA, 8'hC3);
    $display("clock select test done");
    print_verdict;
  end
endmodule // async_serial_port_core_test
